//--- dv/pix_source.sv
// Purpose: upstream pixel source model feeding the lookup table block.
// Assumes: pixels are queued by the bench through push, one per cycle.
// Notes: slow mode leaves idle cycles between pixels to vary the input timing.
`timescale 1ns/1ps
module pix_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [11:0] push_data,
  input wire logic push_mono,
  input wire logic slow,
  output logic [11:0] pix_in_data,
  output logic pix_in_mono,
  output logic pix_in_valid,
  input wire logic pix_in_ready
);
  // ==========================================================
  // pending pixels and handshake
  logic [12:0] q[$];
  int gap = 0;
  always @(posedge aclk) begin
    if (push)
      q.push_back({push_mono, push_data});
    if (!aresetn) begin
      pix_in_valid <= 1'b0;
      pix_in_data <= 12'h000;
      pix_in_mono <= 1'b0;
    end else if (pix_in_valid && pix_in_ready) begin
      // released lines flip so a stale pixel is never mistaken for a new one
      pix_in_valid <= 1'b0;
      pix_in_data <= ~pix_in_data;
      pix_in_mono <= ~pix_in_mono;
      gap <= slow ? 3 : 0;
      void'(q.pop_front());
    end else if (gap > 0)
      gap <= gap - 1;
    else if (!pix_in_valid && q.size() > 0) begin
      pix_in_valid <= 1'b1;
      {pix_in_mono, pix_in_data} <= q[0];
    end
  end
endmodule

//--- dv/tb.sv
// Purpose: self-checking bench of the monochrome lookup table block.
// Assumes: pix_source stands upstream; the bench is the sink and the bus master.
// Notes: expected pixels wait in exp_q and are compared as they leave.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t %h vs %h", $time, a, b); end end
module tb;
  // ==========================================================
  // signals
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic pix_out_ready = 1, push = 0, push_mono = 0, slow = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'h0;
  logic [11:0] push_data = 12'h000;
  logic [1:0] rs;
  logic [15:0] ev;
  logic [15:0] exp_q[$];
  int miscompares = 0, checks = 0, cyc = 0;
  wire awready, wready, bvalid, arready, rvalid, pix_in_mono, pix_in_valid, pix_in_ready, pix_out_valid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] pix_in_data;
  wire [15:0] pix_out_data;
  always #20 aclk = ~aclk;
  mono_pixel_lookup_table i_mono_pixel_lookup_table (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pix_in_data(pix_in_data), .pix_in_mono(pix_in_mono),
    .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .pix_out_data(pix_out_data),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready));
  pix_source i_pix_source (.aclk(aclk), .aresetn(aresetn), .push(push), .push_data(push_data),
    .push_mono(push_mono), .slow(slow), .pix_in_data(pix_in_data), .pix_in_mono(pix_in_mono),
    .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready));
  // ==========================================================
  // bus, pixel and closing tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, lut_pkg::RESP_OKAY)
    // one idle edge, so the next call never re-drives bready in this time step
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic px(input logic [11:0] d, input logic m, input logic [15:0] e);
    push <= 1'b1;
    push_data <= d;
    push_mono <= m;
    exp_q.push_back(e);
    @(posedge aclk);
    push <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic drain;
    while (exp_q.size() != 0)
      @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  function automatic logic [15:0] omask(input int c);
    case (c)
      0, 1, 4: return 16'h00ff;
      2: return 16'h03ff;
      5: return 16'h0fff;
      default: return 16'hffff;
    endcase
  endfunction
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // sink check and hang guard
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && pix_out_valid && pix_out_ready) begin
      ev = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
      `CHK(pix_out_data, ev)
    end
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdr(8'h00);
    `CHK(rd[0], 1'b0)
    rdr(8'h14);
    `CHK(rd[4:0], 5'h10)
    rdr(8'h1c);
    `CHK(rs, 2'h2)
    rdr(8'h18);
    `CHK(rd, 32'h0000_0000)
    $display("test reset done");
  endtask
  task automatic t_sets;
    // value 7 is not a configuration, so the last one must stay
    for (int c = 0; c < 8; c++) begin
      wr(8'h04, c);
      rdr(8'h14);
      `CHK(rd[4:0], c == 0 ? 5'h10 : c < 4 ? 5'h04 : 5'h01)
      rdr(8'h04);
      `CHK(rd[2:0], c > 6 ? 3'h6 : 3'(c))
    end
    $display("test sets done");
  endtask
  task automatic t_bypass;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    px(12'h3ab, 1'b1, 16'h00ab);
    px(12'habc, 1'b0, 16'h0abc);
    drain();
    rdr(8'h18);
    `CHK(rd, 32'h0000_0002)
    $display("test bypass done");
  endtask
  task automatic t_lut8;
    wr(8'h0c, 32'h0003_00fe);
    wr(8'h10, 32'h1234);
    wr(8'h10, 32'h5678);
    wr(8'h0c, 32'h0000_00fe);
    wr(8'h10, 32'haaaa);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h1);
    px(12'hffe, 1'b1, 16'h0034);
    px(12'h0ff, 1'b1, 16'h0078);
    px(12'h0fe, 1'b0, 16'h00fe);
    drain();
    wr(8'h08, 32'h0);
    px(12'h0fe, 1'b1, 16'h00aa);
    drain();
    wr(8'h08, 32'h13);
    px(12'h0fe, 1'b1, 16'h0034);
    drain();
    $display("test lut8 done");
  endtask
  task automatic t_wide;
    for (int c = 1; c < 7; c++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, c);
      wr(8'h0c, c < 4 ? 32'h3ff : 32'hfff);
      wr(8'h10, 32'hbeef);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h1);
      px(12'hfff, 1'b1, 16'hbeef & omask(c));
      drain();
    end
    wr(8'h00, 32'h0);
    px(12'hfff, 1'b1, 16'h0fff);
    drain();
    $display("test wide done");
  endtask
  task automatic t_stall;
    // sink holds off, so the two-entry buffer must refuse rather than drop
    pix_out_ready <= 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 6; i++)
      px(12'(i * 12'h123), 1'b1, 16'(i * 12'h123));
    repeat (30) @(posedge aclk);
    `CHK(pix_in_ready, 1'b0)
    pix_out_ready <= 1'b1;
    drain();
    slow <= 1'b0;
    $display("test stall done");
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_sets();
    t_bypass();
    t_lut8();
    t_wide();
    t_stall();
    // a reset in mid-run must bring enable, configuration and count back
    wr(8'h00, 32'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    end_sim();
  end
endmodule

//--- rtl/lut_pkg.sv
// Purpose: shared constants and types of the monochrome pixel lookup table.
// Assumes: AXI4-Lite register access with 32-bit data and an 8-bit byte address.
// Notes: one table store of 4096 words serves every configuration.
package lut_pkg;
  // ==========================================================
  // configurations
  typedef enum logic [2:0] {
    cfg_in8_out8, cfg_in10_out8, cfg_in10_out10, cfg_in10_out16,
    cfg_in12_out8, cfg_in12_out12, cfg_in12_out16
  } table_config_t;
  localparam logic [2:0] CFG_LAST = 3'h6;
  localparam table_config_t CFG_RST = cfg_in8_out8;
  // ==========================================================
  // widths and sizes
  localparam int ADDR_W = 8;
  localparam int PIX_IN_W = 12;
  localparam int PIX_OUT_W = 16;
  localparam int MEM_AW = 12;
  localparam int MEM_DEPTH = 4096;
  localparam logic [4:0] SETS_IN8 = 5'h10;
  localparam logic [4:0] SETS_IN10 = 5'h04;
  localparam logic [4:0] SETS_IN12 = 5'h01;
  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SET_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LOAD_PTR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LOAD_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PIX_COUNT = 8'h18;
  // ==========================================================
  // field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int PTR_SET_LSB = 16;
  localparam int STAT_HEAD_BIT = 8;
  localparam int STAT_SKID_BIT = 9;
  localparam int STAT_S1_BIT = 10;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [3:0] SET_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/mono_pixel_lookup_table.sv
// Purpose: lookup table transform of a monochrome pixel stream, set up over AXI4-Lite.
// Assumes: pixel source and sink run on aclk; tables are loaded while the table is off.
// Notes: the table store is one 4096-word array; the configuration decides how the
//   selected data set and the pixel value split its address.
// How it works
// - Pixels flagged as colour bypass the table and leave unchanged.
// - The 8-in configuration indexes with 8 pixel bits and returns 8 output bits.
// - The 10-in configurations index with 10 pixel bits and return 8, 10 or 16 bits.
// - The 12-in configurations index with 12 pixel bits and return 8, 12 or 16 bits.
// - A data set is exactly one table, since monochrome pixels have one component.
// - 16 data sets exist for 8-in, 4 for 10-in and 1 for 12-in; set numbers wrap to that.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module mono_pixel_lookup_table (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lut_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lut_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [lut_pkg::PIX_IN_W-1:0] pix_in_data,
  input wire logic pix_in_mono,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  output logic [lut_pkg::PIX_OUT_W-1:0] pix_out_data,
  output logic pix_out_valid,
  input wire logic pix_out_ready
);
  // ==========================================================
  // configuration helpers
  function automatic logic [4:0] sets_of(input lut_pkg::table_config_t c);
    if (c == lut_pkg::cfg_in8_out8) begin
      return lut_pkg::SETS_IN8;
    end else if (c == lut_pkg::cfg_in12_out8 || c == lut_pkg::cfg_in12_out12 || c == lut_pkg::cfg_in12_out16) begin
      return lut_pkg::SETS_IN12;
    end
    return lut_pkg::SETS_IN10;
  endfunction

  function automatic logic [11:0] in_mask(input lut_pkg::table_config_t c);
    logic [4:0] s;
    s = sets_of(c);
    if (s == lut_pkg::SETS_IN8) begin
      return 12'h0ff;
    end else if (s == lut_pkg::SETS_IN10) begin
      return 12'h3ff;
    end
    return 12'hfff;
  endfunction

  function automatic logic [15:0] out_mask(input lut_pkg::table_config_t c);
    case (c)
      lut_pkg::cfg_in10_out10: return 16'h03ff;
      lut_pkg::cfg_in12_out12: return 16'h0fff;
      lut_pkg::cfg_in10_out16, lut_pkg::cfg_in12_out16: return 16'hffff;
      default: return 16'h00ff;
    endcase
  endfunction

  // set bits sit above the pixel bits; fewer sets leave more room for the index
  function automatic logic [11:0] lut_addr(input lut_pkg::table_config_t c, input logic [3:0] set,
                                           input logic [11:0] idx);
    logic [4:0] s;
    s = sets_of(c);
    if (s == lut_pkg::SETS_IN8) begin
      return {set, idx[7:0]};
    end else if (s == lut_pkg::SETS_IN10) begin
      return {set[1:0], idx[9:0]};
    end
    return idx;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // ==========================================================
  // registers
  logic enable_r;
  lut_pkg::table_config_t cfg_r;
  logic [3:0] set_sel_r, load_set_r, wstrb_r, set_eff, load_set_eff;
  logic [11:0] load_idx_r;
  logic [31:0] pix_count_r, wdata_r, wr_val, rd_val, ptr_old;
  logic [lut_pkg::ADDR_W-1:0] awaddr_r;
  logic do_write, rd_ok, wr_ok, accept, pop, s1_valid_r, skid_valid_r;
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign set_eff = set_sel_r & 4'(sets_of(cfg_r) - 5'h01);
  assign load_set_eff = load_set_r & 4'(sets_of(cfg_r) - 5'h01);
  assign ptr_old = {12'h000, load_set_r, 4'h0, load_idx_r};
  always_comb begin
    wr_ok = 1'b1;
    wr_val = 32'h0000_0000;
    if (awaddr_r == lut_pkg::OFS_CTRL) begin
      wr_val = merge({31'h0000_0000, enable_r}, wdata_r, wstrb_r);
    end else if (awaddr_r == lut_pkg::OFS_CONFIG) begin
      wr_val = merge({29'h0000_0000, cfg_r}, wdata_r, wstrb_r);
    end else if (awaddr_r == lut_pkg::OFS_SET_SEL) begin
      wr_val = merge({28'h000_0000, set_sel_r}, wdata_r, wstrb_r);
    end else if (awaddr_r == lut_pkg::OFS_LOAD_PTR) begin
      wr_val = merge(ptr_old, wdata_r, wstrb_r);
    end else if (awaddr_r == lut_pkg::OFS_LOAD_DATA) begin
      wr_val = wdata_r;
    end else if (awaddr_r != lut_pkg::OFS_STATUS && awaddr_r != lut_pkg::OFS_PIX_COUNT) begin
      wr_ok = 1'b0;
    end
  end

  // ==========================================================
  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lut_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr & 8'hfc;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? lut_pkg::RESP_OKAY : lut_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= lut_pkg::CTRL_RST;
      cfg_r <= lut_pkg::CFG_RST;
      set_sel_r <= lut_pkg::SET_RST;
      load_set_r <= lut_pkg::SET_RST;
      load_idx_r <= 12'h000;
    end else if (do_write) begin
      if (awaddr_r == lut_pkg::OFS_CTRL) begin
        enable_r <= wr_val[lut_pkg::CTRL_EN_BIT];
      end else if (awaddr_r == lut_pkg::OFS_CONFIG && wr_val[2:0] <= lut_pkg::CFG_LAST) begin
        cfg_r <= lut_pkg::table_config_t'(wr_val[2:0]);
        // a new configuration moves the table layout, so loading restarts
        load_set_r <= lut_pkg::SET_RST;
        load_idx_r <= 12'h000;
      end else if (awaddr_r == lut_pkg::OFS_SET_SEL) begin
        set_sel_r <= wr_val[3:0];
      end else if (awaddr_r == lut_pkg::OFS_LOAD_PTR) begin
        load_set_r <= wr_val[lut_pkg::PTR_SET_LSB +: 4];
        load_idx_r <= wr_val[11:0] & in_mask(cfg_r);
      end else if (awaddr_r == lut_pkg::OFS_LOAD_DATA) begin
        load_idx_r <= (load_idx_r + 12'h001) & in_mask(cfg_r);
      end
    end
  end

  // ==========================================================
  // table store; loading during streaming is allowed but mixes tables
  logic [15:0] table_mem [lut_pkg::MEM_DEPTH];
  logic [15:0] mem_q_r;
  logic [11:0] rd_addr;

  assign accept = pix_in_valid && pix_in_ready;
  assign rd_addr = lut_addr(cfg_r, set_eff, pix_in_data & in_mask(cfg_r));

  always_ff @(posedge aclk) begin
    if (do_write && awaddr_r == lut_pkg::OFS_LOAD_DATA && wstrb_r[1:0] == 2'h3) begin
      table_mem[lut_addr(cfg_r, load_set_eff, load_idx_r)] <= wr_val[15:0];
    end
    if (accept) begin
      mem_q_r <= table_mem[rd_addr];
    end
  end

  // ==========================================================
  // read channel
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr[7:2] == lut_pkg::OFS_CTRL[7:2]) begin
      rd_val = {31'h0000_0000, enable_r};
    end else if (s_axi_araddr[7:2] == lut_pkg::OFS_CONFIG[7:2]) begin
      rd_val = {29'h0000_0000, cfg_r};
    end else if (s_axi_araddr[7:2] == lut_pkg::OFS_SET_SEL[7:2]) begin
      rd_val = {28'h000_0000, set_sel_r};
    end else if (s_axi_araddr[7:2] == lut_pkg::OFS_LOAD_PTR[7:2]) begin
      rd_val = ptr_old;
    end else if (s_axi_araddr[7:2] == lut_pkg::OFS_LOAD_DATA[7:2]) begin
      rd_val = 32'h0000_0000;
    end else if (s_axi_araddr[7:2] == lut_pkg::OFS_STATUS[7:2]) begin
      rd_val = {21'h00_0000, s1_valid_r, skid_valid_r, pix_out_valid, 3'h0, sets_of(cfg_r)};
    end else if (s_axi_araddr[7:2] == lut_pkg::OFS_PIX_COUNT[7:2]) begin
      rd_val = pix_count_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lut_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? lut_pkg::RESP_OKAY : lut_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // lookup stage
  logic s1_pass_r;
  logic [11:0] s1_raw_r;
  logic [15:0] s1_omask_r, s1_result;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_valid_r <= 1'b0;
      s1_pass_r <= 1'b1;
      s1_raw_r <= 12'h000;
      s1_omask_r <= 16'h0000;
      pix_count_r <= 32'h0000_0000;
    end else begin
      s1_valid_r <= accept;
      if (accept) begin
        s1_pass_r <= !pix_in_mono || !enable_r;
        s1_raw_r <= pix_in_mono ? (pix_in_data & in_mask(cfg_r)) : pix_in_data;
        s1_omask_r <= out_mask(cfg_r);
        pix_count_r <= pix_count_r + 32'h0000_0001;
      end
    end
  end

  assign s1_result = s1_pass_r ? {4'h0, s1_raw_r} : (mem_q_r & s1_omask_r);

  // ==========================================================
  // two-entry output buffer: head drives the port, skid takes a stalled word
  logic [15:0] skid_data_r;
  logic [1:0] occ_nxt;
  assign pop = pix_out_valid && pix_out_ready;
  // the lookup stage always lands next cycle, so it counts against the room
  assign occ_nxt = 2'(2'(pix_out_valid) + 2'(skid_valid_r) + 2'(s1_valid_r) + 2'(accept) - 2'(pop));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_out_valid <= 1'b0;
      pix_out_data <= 16'h0000;
      skid_valid_r <= 1'b0;
      skid_data_r <= 16'h0000;
      pix_in_ready <= 1'b0;
    end else begin
      pix_in_ready <= occ_nxt < 2'h2;
      if (pop || !pix_out_valid) begin
        if (skid_valid_r) begin
          pix_out_valid <= 1'b1;
          pix_out_data <= skid_data_r;
          skid_valid_r <= s1_valid_r;
          skid_data_r <= s1_result;
        end else begin
          pix_out_valid <= s1_valid_r;
          pix_out_data <= s1_result;
        end
      end else if (s1_valid_r) begin
        skid_valid_r <= 1'b1;
        skid_data_r <= s1_result;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_ready;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_write_answer;
    s_axi_bvalid && s_axi_awready == 1'b0 && s_axi_wready == 1'b0;
  endsequence

  AST_WRITE_RESP: assert property (s_write_ready |=> s_write_answer)
    else $error("write response missing after address and data");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  AST_NO_OVERRUN: assert property (s1_valid_r && pix_out_valid && skid_valid_r |-> pop)
    else $error("output buffer overrun");
  AST_COLOR_BYPASS: assert property (accept && !pix_in_mono |=> s1_result == {4'h0, $past(pix_in_data)})
    else $error("colour pixel was transformed");
  AST_OUT8: assert property (accept && pix_in_mono && enable_r && out_mask(cfg_r) == 16'h00ff
                             |=> s1_result[15:8] == 8'h00)
    else $error("8-bit output wider than 8 bits");
  AST_IN10_INDEX: assert property (accept && sets_of(cfg_r) == lut_pkg::SETS_IN10
                                   |-> rd_addr == {set_sel_r[1:0], pix_in_data[9:0]})
    else $error("10-bit index wrong");
  AST_IN12_INDEX: assert property (accept && sets_of(cfg_r) == lut_pkg::SETS_IN12 |-> rd_addr == pix_in_data)
    else $error("12-bit index wrong");
  AST_SET_LIMIT: assert property ({1'b0, set_eff} < sets_of(cfg_r))
    else $error("data set beyond configuration limit");
  AST_DISABLED_PASS: assert property (accept && !enable_r ##1 s1_valid_r[*1] |-> s1_pass_r ##1 pix_out_valid)
    else $error("disabled table did not pass pixel");
endmodule
